// file: rtl/mbw_addr_decode.sv
// Purpose: Classify one register address of a write
// Assumes: Purely combinational, same clock as the caller
// Notes: Alias range strips the top bit and never saves
`timescale 1ns/1ps
module mbw_addr_decode (
    // Address in
    input wire logic [15:0] addr,
    // Classification
    output logic is_param,
    output logic is_volatile,
    output logic is_command,
    output logic [7:0] param_group,
    output logic [7:0] param_index
);
    wire logic [15:0] base_addr;
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign is_volatile = addr[15]; // RULE_07
    assign base_addr = {1'b0, addr[14:0]}; // RULE_07
    assign is_param = (base_addr <= mbw_pkg::PARAM_LAST); // RULE_06
    assign is_command = !addr[15] && (addr >= mbw_pkg::CMD_FIRST) && (addr <= mbw_pkg::CMD_LAST);
    assign param_group = base_addr[15:8]; // RULE_06
    assign param_index = base_addr[7:0]; // RULE_06
endmodule

// file: rtl/mbw_handler.sv
// Purpose: Slave handler for the write multiple registers request
// Assumes: Framing layer delivers request bytes and takes response bytes
// Notes: Whole request is buffered and its counts and address checked before any write; the run lock is checked at each write
//
// Overview of operation
// RULE_01 - Function 0x10 writes 1 to 16 contiguous registers from the start address.
// RULE_02 - Values arrive high byte first; byte count must be twice register count.
// RULE_03 - Good write answers function, start address and count, no data echo.
// RULE_04 - Failed write answers 0x90 then a one-byte exception code.
// RULE_05 - Master should avoid this function for often changed parameters.
// RULE_06 - Parameter address: high byte is group, low byte is index.
// RULE_07 - Address plus 8000H applies at once and is never saved.
// RULE_08 - Run-locked parameters are refused with exception 1 while running.
// RULE_09 - Bad count or byte count writes nothing and answers an exception.
`timescale 1ns/1ps
module mbw_handler (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request byte stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_end,
    // Drive state
    input wire logic drive_running,
    input wire logic run_locked,
    // Response byte stream
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    // Parameter write port
    output logic par_we,
    output logic par_save,
    output logic [7:0] par_group,
    output logic [7:0] par_index,
    output logic [15:0] par_data,
    output logic [15:0] par_addr,
    // Command area
    output logic [15:0] run_command_word,
    output logic [15:0] main_channel_freq_setpoint,
    output logic [15:0] aux_channel_freq_setpoint,
    output logic [15:0] torque_setpoint,
    output logic [15:0] process_loop_setpoint,
    output logic [15:0] process_loop_feedback,
    output logic [15:0] separated_voltage_setpoint,
    output logic [15:0] upper_freq_limit_setpoint,
    // Handler state
    output logic busy
);
    mbw_pkg::mbw_state_t st_q;
    logic [15:0] start_q, count_q, wr_addr_q;
    logic [7:0] bytes_q, exc_q, hi_q;
    logic [4:0] n_q;
    logic [4:0] w_q;
    logic [2:0] rsp_q;
    logic err_q, extra_q;
    logic [15:0] vals_q [0:15];
    logic [15:0] cmd_q [0:7];

    wire logic dec_param, dec_vol, dec_cmd;
    wire logic [7:0] dec_group, dec_index;
    wire logic count_ok, bytes_ok, lock_hit, addr_bad;
    wire logic [16:0] end_addr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    assign count_ok = (count_q >= mbw_pkg::COUNT_MIN) && (count_q <= mbw_pkg::COUNT_MAX); // RULE_01
    assign bytes_ok = ({8'h00, bytes_q} == {count_q[14:0], 1'b0}); // RULE_02
    assign lock_hit = drive_running && run_locked && dec_param; // RULE_08
    assign end_addr = {1'b0, start_q} + {1'b0, count_q} - 17'h00001;
    assign addr_bad = end_addr[16];

    mbw_addr_decode u_dec (
        .addr(wr_addr_q),
        .is_param(dec_param),
        .is_volatile(dec_vol),
        .is_command(dec_cmd),
        .param_group(dec_group),
        .param_index(dec_index)
    );

    function automatic logic [2:0] cmd_slot(input logic [15:0] a);
        logic [2:0] s;
        s = 3'h7;
        if (a == mbw_pkg::REG_RUN_COMMAND_WORD) s = 3'h0;
        else if (a == mbw_pkg::REG_MAIN_CHANNEL_FREQ_SETPOINT) s = 3'h1;
        else if (a == mbw_pkg::REG_AUX_CHANNEL_FREQ_SETPOINT) s = 3'h2;
        else if (a == mbw_pkg::REG_TORQUE_SETPOINT) s = 3'h3;
        else if (a == mbw_pkg::REG_PROCESS_LOOP_SETPOINT) s = 3'h4;
        else if (a == mbw_pkg::REG_PROCESS_LOOP_FEEDBACK) s = 3'h5;
        else if (a == mbw_pkg::REG_SEPARATED_VOLTAGE_SETPOINT) s = 3'h6;
        return s;
    endfunction

    wire logic cmd_known;
    assign cmd_known = (cmd_slot(wr_addr_q) != 3'h7) || (wr_addr_q == mbw_pkg::REG_UPPER_FREQ_LIMIT_SETPOINT);
    wire logic [2:0] slot;
    assign slot = (wr_addr_q == mbw_pkg::REG_UPPER_FREQ_LIMIT_SETPOINT) ? 3'h7 : cmd_slot(wr_addr_q);

    assign run_command_word = cmd_q[0];
    assign main_channel_freq_setpoint = cmd_q[1];
    assign aux_channel_freq_setpoint = cmd_q[2];
    assign torque_setpoint = cmd_q[3];
    assign process_loop_setpoint = cmd_q[4];
    assign process_loop_feedback = cmd_q[5];
    assign separated_voltage_setpoint = cmd_q[6];
    assign upper_freq_limit_setpoint = cmd_q[7];

    // ------------------------------------------------------------
    // Request parse, check, write and reply
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
        par_we <= 1'b0;
        if (rst) begin
            st_q <= mbw_pkg::ST_FUNC;
            start_q <= 16'h0000;
            count_q <= 16'h0000;
            wr_addr_q <= 16'h0000;
            bytes_q <= 8'h00;
            exc_q <= 8'h00;
            hi_q <= 8'h00;
            n_q <= 5'h00;
            w_q <= 5'h00;
            rsp_q <= 3'h0;
            err_q <= 1'b0;
            extra_q <= 1'b0;
            tx_byte <= 8'h00;
            par_save <= 1'b0;
            par_group <= 8'h00;
            par_index <= 8'h00;
            par_data <= 16'h0000;
            par_addr <= 16'h0000;
            busy <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                cmd_q[i] <= mbw_pkg::CMD_RESET;
            end
        end else begin
            case (st_q)
                mbw_pkg::ST_FUNC: begin
                    busy <= 1'b0;
                    err_q <= 1'b0;
                    extra_q <= 1'b0;
                    n_q <= 5'h00;
                    if (rx_valid && rx_byte == mbw_pkg::FUNC_WRITE_MULTI) begin // RULE_01
                        st_q <= mbw_pkg::ST_ADDR_HI;
                        busy <= 1'b1;
                    end
                end
                mbw_pkg::ST_ADDR_HI: if (rx_valid) begin
                    start_q[15:8] <= rx_byte;
                    st_q <= mbw_pkg::ST_ADDR_LO;
                end
                mbw_pkg::ST_ADDR_LO: if (rx_valid) begin
                    start_q[7:0] <= rx_byte;
                    st_q <= mbw_pkg::ST_CNT_HI;
                end
                mbw_pkg::ST_CNT_HI: if (rx_valid) begin
                    count_q[15:8] <= rx_byte;
                    st_q <= mbw_pkg::ST_CNT_LO;
                end
                mbw_pkg::ST_CNT_LO: if (rx_valid) begin
                    count_q[7:0] <= rx_byte;
                    st_q <= mbw_pkg::ST_BYTES;
                end
                mbw_pkg::ST_BYTES: if (rx_valid) begin
                    bytes_q <= rx_byte;
                    st_q <= (rx_byte == 8'h00 || rx_end) ? mbw_pkg::ST_CHECK : mbw_pkg::ST_VAL_HI;
                end
                mbw_pkg::ST_VAL_HI: if (rx_valid) begin
                    hi_q <= rx_byte; // RULE_02
                    st_q <= mbw_pkg::ST_VAL_LO;
                end
                mbw_pkg::ST_VAL_LO: if (rx_valid) begin
                    if (n_q < 5'h10) begin
                        vals_q[n_q[3:0]] <= {hi_q, rx_byte}; // RULE_02
                    end else begin
                        extra_q <= 1'b1;
                    end
                    n_q <= n_q + 5'h01;
                    st_q <= rx_end ? mbw_pkg::ST_CHECK : mbw_pkg::ST_VAL_HI;
                end
                mbw_pkg::ST_CHECK: begin
                    w_q <= 5'h00;
                    wr_addr_q <= start_q;
                    if (!count_ok || !bytes_ok || extra_q || {11'h000, n_q} != count_q) begin // RULE_09
                        err_q <= 1'b1;
                        exc_q <= mbw_pkg::EXC_BAD_VALUE;
                        st_q <= mbw_pkg::ST_REPLY;
                    end else if (addr_bad) begin
                        err_q <= 1'b1;
                        exc_q <= mbw_pkg::EXC_BAD_ADDR;
                        st_q <= mbw_pkg::ST_REPLY;
                    end else begin
                        st_q <= mbw_pkg::ST_WRITE;
                    end
                    rsp_q <= 3'h0;
                end
                mbw_pkg::ST_WRITE: begin
                    if (lock_hit) begin // RULE_08
                        err_q <= 1'b1;
                        exc_q <= mbw_pkg::EXC_RUN_LOCKED;
                        st_q <= mbw_pkg::ST_REPLY;
                    end else begin
                        if (dec_cmd && cmd_known) begin
                            cmd_q[slot] <= vals_q[w_q[3:0]];
                        end else if (dec_param) begin
                            par_we <= 1'b1; // RULE_01
                            par_save <= !dec_vol; // RULE_07
                            par_group <= dec_group; // RULE_06
                            par_index <= dec_index; // RULE_06
                            par_addr <= wr_addr_q;
                            par_data <= vals_q[w_q[3:0]];
                        end
                        wr_addr_q <= wr_addr_q + 16'h0001; // RULE_01
                        w_q <= w_q + 5'h01;
                        if ({11'h000, w_q + 5'h01} == count_q) begin
                            st_q <= mbw_pkg::ST_REPLY;
                        end
                    end
                end
                mbw_pkg::ST_REPLY: begin
                    tx_valid <= 1'b1;
                    rsp_q <= rsp_q + 3'h1;
                    if (err_q) begin // RULE_04
                        tx_byte <= (rsp_q == 3'h0) ? mbw_pkg::FUNC_WRITE_MULTI_ERR : exc_q;
                        tx_last <= (rsp_q == 3'h1);
                        if (rsp_q == 3'h1) st_q <= mbw_pkg::ST_FUNC;
                    end else begin // RULE_03
                        case (rsp_q)
                            3'h0: tx_byte <= mbw_pkg::FUNC_WRITE_MULTI;
                            3'h1: tx_byte <= start_q[15:8];
                            3'h2: tx_byte <= start_q[7:0];
                            3'h3: tx_byte <= count_q[15:8];
                            default: tx_byte <= count_q[7:0];
                        endcase
                        tx_last <= (rsp_q == 3'h4);
                        if (rsp_q == 3'h4) st_q <= mbw_pkg::ST_FUNC;
                    end
                end
                default: st_q <= mbw_pkg::ST_FUNC;
            endcase
        end
    end
endmodule

// file: rtl/mbw_pkg.sv
// Purpose: Constants for the multi-register write handler
// Assumes: Byte-wide request and response streams from a framing layer
// Notes: Register offsets are the Modbus register addresses
package mbw_pkg;
    // ------------------------------------------------------------
    // Function and exception codes, register count limits
    // ------------------------------------------------------------
    localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FUNC_WRITE_MULTI_ERR = 8'h90;
    localparam logic [7:0] EXC_RUN_LOCKED = 8'h01;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [15:0] COUNT_MIN = 16'h0001;
    localparam logic [15:0] COUNT_MAX = 16'h0010;
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [15:0] PARAM_LAST = 16'h6F63;
    localparam logic [15:0] VOLATILE_BASE = 16'h8000;
    localparam logic [15:0] CMD_FIRST = 16'h7000;
    localparam logic [15:0] CMD_LAST = 16'h71FF;
    localparam logic [15:0] REG_RUN_COMMAND_WORD = 16'h7000;
    localparam logic [15:0] REG_MAIN_CHANNEL_FREQ_SETPOINT = 16'h7001;
    localparam logic [15:0] REG_AUX_CHANNEL_FREQ_SETPOINT = 16'h7002;
    localparam logic [15:0] REG_TORQUE_SETPOINT = 16'h7003;
    localparam logic [15:0] REG_PROCESS_LOOP_SETPOINT = 16'h7004;
    localparam logic [15:0] REG_PROCESS_LOOP_FEEDBACK = 16'h7005;
    localparam logic [15:0] REG_SEPARATED_VOLTAGE_SETPOINT = 16'h7006;
    localparam logic [15:0] REG_UPPER_FREQ_LIMIT_SETPOINT = 16'h700A;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    // ------------------------------------------------------------
    // Handler states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_FUNC = 4'h0,
        ST_ADDR_HI = 4'h1,
        ST_ADDR_LO = 4'h2,
        ST_CNT_HI = 4'h3,
        ST_CNT_LO = 4'h4,
        ST_BYTES = 4'h5,
        ST_VAL_HI = 4'h6,
        ST_VAL_LO = 4'h7,
        ST_CHECK = 4'h8,
        ST_WRITE = 4'h9,
        ST_REPLY = 4'hA
    } mbw_state_t;
endpackage

// file: tb/mbw_master.sv
// Purpose: Request side model of the bus master
// Assumes: One byte per cycle, driven at the falling edge
// Notes: Idle byte lines show the inverted last byte, never a stale copy
`timescale 1ns/1ps
module mbw_master (
    // Clock
    input wire logic clock,
    // Request stream
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_end
);
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'hA5;
        rx_end = 1'b0;
    end
    // Only short frames reach the store, so the store is not worn by the bench
    task automatic send(input logic [7:0] q[$]);
        for (int i = 0; i < q.size(); i++) begin
            @(negedge clock);
            rx_valid = 1'b1;
            rx_byte = q[i];
            rx_end = (i == q.size() - 1);
        end
        @(negedge clock);
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
        rx_end = 1'b0;
    endtask
endmodule

// file: tb/mbw_props.sv
// Purpose: Port checks for the write handler
// Assumes: One clock, synchronous reset
// Notes: Bound to every handler instance
`timescale 1ns/1ps
module mbw_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Observed ports
    input wire logic drive_running,
    input wire logic run_locked,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic par_we,
    input wire logic par_save,
    input wire logic [7:0] par_group,
    input wire logic [7:0] par_index,
    input wire logic [15:0] par_addr
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Length of the current write burst; 5 bits so a runaway still shows
    logic [4:0] run_q;
    logic [4:0] run_d;
    assign run_d = par_we ? run_q + 5'h01 : 5'h00;
    always_ff @(posedge clock) run_q <= rst ? 5'h00 : run_d;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_ok_tail;
        (tx_valid && !tx_last) [*3] ##1 (tx_valid && tx_last);
    endsequence
    property p_ok_resp;
        $rose(tx_valid) && tx_byte == mbw_pkg::FUNC_WRITE_MULTI |=> s_ok_tail;
    endproperty
    a_ok_resp: assert property (p_ok_resp) else $error("normal reply not five bytes");
    property p_err_resp;
        $rose(tx_valid) && tx_byte == mbw_pkg::FUNC_WRITE_MULTI_ERR |=> tx_valid && tx_last;
    endproperty
    a_err_resp: assert property (p_err_resp) else $error("error reply not two bytes");
    property p_last;
        tx_last |-> tx_valid ##1 !tx_valid;
    endproperty
    a_last: assert property (p_last) else $error("reply end marker misplaced");
    property p_burst;
        par_we |-> run_q < 5'h10;
    endproperty
    a_burst: assert property (p_burst) else $error("more than sixteen writes");
    property p_alias;
        par_we && par_addr[15] |-> !par_save;
    endproperty
    a_alias: assert property (p_alias) else $error("alias write saved");
    property p_save;
        par_we && par_addr <= mbw_pkg::PARAM_LAST |-> par_save;
    endproperty
    a_save: assert property (p_save) else $error("parameter write not saved");
    property p_split;
        par_we |-> par_group == {1'b0, par_addr[14:8]} && par_index == par_addr[7:0];
    endproperty
    a_split: assert property (p_split) else $error("group or index wrong");
    property p_lock;
        par_we |-> !($past(drive_running) && $past(run_locked));
    endproperty
    a_lock: assert property (p_lock) else $error("locked parameter written");
endmodule
bind mbw_handler mbw_props u_props (.clock(clock), .rst(rst), .drive_running(drive_running),
    .run_locked(run_locked), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .par_we(par_we),
    .par_save(par_save), .par_group(par_group), .par_index(par_index), .par_addr(par_addr));

// file: tb/tb_mbw_handler.sv
// Purpose: Self-checking bench for the write handler
// Assumes: Master model sends the requests
// Notes: Reply bytes and writes captured at rising edges
`timescale 1ns/1ps
module tb_mbw_handler;
    logic clock;
    logic rst;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic rx_end;
    logic drive_running;
    logic run_locked;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_last;
    logic par_we;
    logic par_save;
    logic [15:0] par_addr;
    logic [15:0] par_data;
    logic busy;
    logic [15:0] cmd [8];
    logic [7:0] rq[$];
    logic [32:0] wq[$];
    int fails;
    int n_tests;
    int cyc;
    mbw_master u_master (.clock(clock), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end));
    mbw_handler dut (.clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
        .drive_running(drive_running), .run_locked(run_locked), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_last(tx_last), .par_we(par_we), .par_save(par_save), .par_group(), .par_index(),
        .par_data(par_data), .par_addr(par_addr), .run_command_word(cmd[0]),
        .main_channel_freq_setpoint(cmd[1]), .aux_channel_freq_setpoint(cmd[2]), .torque_setpoint(cmd[3]),
        .process_loop_setpoint(cmd[4]), .process_loop_feedback(cmd[5]), .separated_voltage_setpoint(cmd[6]),
        .upper_freq_limit_setpoint(cmd[7]), .busy(busy));
    // ------------------------------------------------------------
    // Clock, capture and scenarios
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (tx_valid === 1'b1) rq.push_back(tx_byte);
        if (par_we === 1'b1) wq.push_back({par_save, par_addr, par_data});
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Waits on reply bytes under a bound, then a short tail to catch extra ones
    task automatic xfer(input logic [7:0] req[$], input logic [7:0] exp[$], input int nw);
        int k;
        rq = {};
        wq = {};
        u_master.send(req);
        chk("busy", 33'(req[0] == 8'h10), 33'(busy));
        k = 0;
        while (rq.size() < exp.size() && k < 200) begin
            @(negedge clock);
            k++;
        end
        repeat (2) @(negedge clock);
        chk("reply length", exp.size(), rq.size());
        foreach (exp[i]) chk("reply byte", exp[i], rq[i]);
        if (nw >= 0) chk("write count", nw, wq.size());
        chk("idle", 33'h000000000, 33'(busy));
    endtask
    task automatic t_two;
        xfer('{8'h10, 8'h03, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h03},
            '{8'h10, 8'h03, 8'h00, 8'h00, 8'h02}, 2);
        chk("first write", {1'b1, 16'h0300, 16'h0001}, wq[0]);
        chk("second write", {1'b1, 16'h0301, 16'h0003}, wq[1]);
    endtask
    task automatic t_alias;
        logic [7:0] q[$];
        q = '{8'h10, 8'h80, 8'h0E, 8'h00, 8'h10, 8'h20};
        for (int i = 0; i < 16; i++) q = {q, 8'h12, 8'(i)};
        xfer(q, '{8'h10, 8'h80, 8'h0E, 8'h00, 8'h10}, 16);
        for (int i = 0; i < 16; i++) chk("alias write", {1'b0, 16'h800E + 16'(i), 8'h12, 8'(i)}, wq[i]);
    endtask
    task automatic t_cmd;
        xfer('{8'h10, 8'h70, 8'h00, 8'h00, 8'h03, 8'h06, 8'h00, 8'h01, 8'h13, 8'h88, 8'hFF, 8'h38},
            '{8'h10, 8'h70, 8'h00, 8'h00, 8'h03}, 0);
        chk("run command", 16'h0001, cmd[0]);
        chk("main setpoint", 16'h1388, cmd[1]);
        chk("aux setpoint", 16'hFF38, cmd[2]);
        chk("torque untouched", 16'h0000, cmd[3]);
        // Unlisted command slots between the two are skipped but still acknowledged
        xfer('{8'h10, 8'h70, 8'h06, 8'h00, 8'h05, 8'h0A, 8'h00, 8'h11, 8'h00, 8'h22, 8'h00, 8'h33,
            8'h00, 8'h44, 8'h00, 8'h55}, '{8'h10, 8'h70, 8'h06, 8'h00, 8'h05}, 0);
        chk("voltage setpoint", 16'h0011, cmd[6]);
        chk("upper limit setpoint", 16'h0055, cmd[7]);
        chk("aux setpoint stands", 16'hFF38, cmd[2]);
    endtask
    task automatic t_bad;
        logic [7:0] none[$];
        xfer('{8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02}, '{8'h90, 8'h03}, 0);
        xfer('{8'h10, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00}, '{8'h90, 8'h03}, 0);
        xfer('{8'h10, 8'hFF, 8'hFF, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02}, '{8'h90, 8'h02}, 0);
        // Another function code is not ours: no reply, no write
        xfer('{8'h06, 8'h00, 8'h05, 8'h00, 8'h09}, none, 0);
    endtask
    task automatic t_lock;
        drive_running = 1'b1;
        run_locked = 1'b1;
        xfer('{8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h00, 8'h09}, '{8'h90, 8'h01}, 0);
        run_locked = 1'b0;
        xfer('{8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h00, 8'h09}, '{8'h10, 8'h00, 8'h05, 8'h00, 8'h01}, 1);
        drive_running = 1'b0;
    endtask
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        drive_running = 1'b0;
        run_locked = 1'b0;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        foreach (cmd[i]) chk("command reset", 16'h0000, cmd[i]);
        t_two();
        t_alias();
        t_cmd();
        t_bad();
        t_lock();
        end_of_test();
    end
endmodule
